//--- rtl/pmw_pkg.sv
// Purpose: constants and types for the power-mode and wake controller
// Assumes: 100 MHz reference clock
// Notes: wake latencies are nominal figures turned into cycle counts
package pmw_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_MHZ = 100;
	localparam int WAKE_IDLE_US = 14;
	localparam int WAKE_STBY_US = 151;
	localparam int WAKE_SHDN_US = 1015;
	localparam int WAKE_IDLE_CYC = WAKE_IDLE_US * CLK_MHZ;
	localparam int WAKE_STBY_CYC = WAKE_STBY_US * CLK_MHZ;
	localparam int WAKE_SHDN_CYC = WAKE_SHDN_US * CLK_MHZ;
	localparam int ENTRY_STEP_CYC = 2;
	// ==========================================================
	// mode requests from software
	typedef enum logic [2:0] {
		PMW_REQ_ACTIVE = 3'h0,
		PMW_REQ_IDLE = 3'h1,
		PMW_REQ_STANDBY = 3'h2,
		PMW_REQ_SHUTDOWN = 3'h3,
		PMW_REQ_LOWEST_A = 3'h4
	} pmw_req_t;
	// reset cause encodings lowest_mode_a in the reset status output
	localparam logic [1:0] CAUSE_POR = 2'h0;
	localparam logic [1:0] CAUSE_PIN = 2'h1;
	localparam logic [1:0] CAUSE_WAKEPIN = 2'h2;
	localparam logic [1:0] CAUSE_RESET_VAL = CAUSE_POR;
	// slow clock source select
	localparam logic SLOW_SEL_RC = 1'b0;
	localparam logic SLOW_SEL_XTAL = 1'b1;
endpackage : pmw_pkg

//--- rtl/pmw_sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: one clock domain on the receiving side
// Notes: output changes only when stage two and three agree
`timescale 1ns/1ps
`default_nettype none
module pmw_sync3 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// asynchronous level in, filtered level out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} pmw_sync_t;
	pmw_sync_t st, next_st;
	// ==========================================================
	// stage one feeds only stage two
	always_comb begin
		next_st = st;
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.q[i] = st.s3[i];
			end
		end
	end
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign sync_out = st.q;
endmodule : pmw_sync3
`default_nettype wire

//--- rtl/pmw_ctrl.sv
// Purpose: power-mode sequencer, wake logic, reset cause and clock select
// Assumes: software mode requests arrive as one-cycle pulses on this clock
// Notes: power and gate outputs are active-high enables
// Behaviour
// - idle stops cpu and memory clocks, active peripherals keep their clocks
// - any interrupt returns idle to active
// - standby keeps only the always-on domain and sensor processor powered
// - standby leaves only on external wake, rtc, sensor processor event or reset pin
// - standby wake resumes cpu where it stopped, retained peripherals keep config
// - gpio pins lowest_mode_a latched throughout standby
// - shutdown powers off everything including always-on domain and sensor processor
// - shutdown latches each pin at its value just before entry
// - wake-pin change in shutdown wakes device as a reset
// - reset cause records wake-pin, reset-pin or power-on reset
// - shutdown keeps only latched pins and nonvolatile memory
// - reset pin wakes all modes; enabled pin edge wakes shutdown only
// - rtc wakes from active, idle and standby only
// - wake latency about 14, 151 and 1015 microseconds by mode
// - always-on domain enabled in every mode except shutdown
// - fast clock is the crystal reference doubled
// - slow rc oscillator serves as slow reference without crystal
// - selected slow clock can drive a gpio pin
// - rtc runs from selected slow clock with optional rc compensation
// - sensor processor configuration decides which conditions wake cpu
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl
	import pmw_pkg::*;
#(
	parameter int NPIN = 31,
	parameter int WAKE_IDLE = pmw_pkg::WAKE_IDLE_CYC,
	parameter int WAKE_STBY = pmw_pkg::WAKE_STBY_CYC,
	parameter int WAKE_SHDN = pmw_pkg::WAKE_SHDN_CYC
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// software mode request
	input wire logic mode_req_valid_in,
	input wire pmw_pkg::pmw_req_t mode_req_in,
	// wake sources
	input wire logic irq_any_in,
	input wire logic ext_wake_in,
	input wire logic rtc_event_in,
	input wire logic sens_event_in,
	input wire logic [15:0] sens_wake_mask_in,
	input wire logic [15:0] sens_cond_in,
	input wire logic reset_pin_n_in,
	// pins and wake configuration
	input wire logic [NPIN-1:0] gpio_val_in,
	input wire logic [NPIN-1:0] gpio_wake_en_in,
	// clock configuration
	input wire logic slow_xtal_fitted_in,
	input wire logic slow_clk_xtal_in,
	input wire logic slow_clk_rc_in,
	input wire logic rtc_comp_en_in,
	input wire logic [7:0] rtc_comp_in,
	input wire logic clkout_en_in,
	// power and clock enables
	output logic cpu_clk_en_out,
	output logic mem_clk_en_out,
	output logic periph_clk_en_out,
	output logic main_pwr_en_out,
	output logic always_on_domain_en_out,
	output logic sens_pwr_en_out,
	output logic retain_en_out,
	output logic fast_pll_x2_out,
	output logic fast_crystal_osc_en_out,
	// pin hold
	output logic io_hold_out,
	output logic [NPIN-1:0] io_latched_out,
	// status
	output logic [2:0] mode_out,
	output logic sys_reset_n_out,
	output logic [1:0] reset_cause_out,
	output logic cpu_resume_out,
	output logic slow_clk_sel_out,
	output logic clkout_pin_out,
	output logic rtc_tick_out
);
	initial begin
		if (NPIN < 1 || NPIN > 32 || WAKE_IDLE < 1 || WAKE_STBY < 1 || WAKE_SHDN < 1) begin
			$error("pmw_ctrl: bad parameter");
		end
	end

	typedef enum logic [3:0] {
		ST_ACTIVE, ST_ENTER_GATE, ST_ENTER_LATCH, ST_IDLE, ST_STANDBY,
		ST_SHUTDOWN, ST_LOWEST_A, ST_WAKE_WAIT, ST_RESET_OUT
	} pmw_st_t;

	typedef struct packed {
		pmw_st_t fsm;
		pmw_req_t target;
		logic [16:0] cnt;
		logic [NPIN-1:0] latched;
		logic [NPIN-1:0] prev_pins;
		logic [1:0] cause;
		logic resume;
		logic wake_reset;
		logic rst_prev;
		logic slow_prev;
		logic [8:0] comp_acc;
		logic tick;
	} pmw_state_t;

	pmw_state_t st, next_st;
	logic [NPIN-1:0] pins_s;
	logic rst_n_s, slow_x_s, slow_r_s, sens_hit;

	// ==========================================================
	// synchronisers for pins and slow clocks
	pmw_sync3 #(.W(NPIN)) u_pin_sync (
		.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
		.async_in(gpio_val_in), .sync_out(pins_s)
	);
	pmw_sync3 #(.W(3)) u_misc_sync (
		.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
		.async_in({reset_pin_n_in, slow_clk_xtal_in, slow_clk_rc_in}),
		.sync_out({rst_n_s, slow_x_s, slow_r_s})
	);

	// only conditions the sensor processor enabled count as a wake
	assign sens_hit = sens_event_in && |(sens_cond_in & sens_wake_mask_in);

	function automatic logic [16:0] wake_cycles(input pmw_req_t m);
		case (m)
			PMW_REQ_IDLE: wake_cycles = 17'(WAKE_IDLE);
			PMW_REQ_STANDBY: wake_cycles = 17'(WAKE_STBY);
			default: wake_cycles = 17'(WAKE_SHDN);
		endcase
	endfunction : wake_cycles

	// ==========================================================
	// sequencer
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		next_st.rst_prev = rst_n_s;
		next_st.prev_pins = pins_s;
		if (st.cnt != '0) begin
			next_st.cnt = st.cnt - 17'h1;
		end
		case (st.fsm)
			ST_ACTIVE: begin
				next_st.latched = pins_s; // pins tracked so latch holds pre-entry value
				if (mode_req_valid_in && mode_req_in != PMW_REQ_ACTIVE) begin
					next_st.target = mode_req_in;
					next_st.cnt = 17'(ENTRY_STEP_CYC);
					next_st.fsm = ST_ENTER_GATE;
				end
			end
			ST_ENTER_GATE: begin
				// clocks are gated first, pins no longer tracked
				if (st.cnt == '0) begin
					if (st.target == PMW_REQ_IDLE) begin
						next_st.fsm = ST_IDLE;
					end else begin
						next_st.cnt = 17'(ENTRY_STEP_CYC);
						next_st.fsm = ST_ENTER_LATCH; // latch before power removal
					end
				end
			end
			ST_ENTER_LATCH: begin
				if (st.cnt == '0) begin
					case (st.target)
						PMW_REQ_STANDBY: next_st.fsm = ST_STANDBY;
						PMW_REQ_SHUTDOWN: next_st.fsm = ST_SHUTDOWN;
						default: next_st.fsm = ST_LOWEST_A;
					endcase
				end
			end
			ST_IDLE: begin
				if (irq_any_in || ext_wake_in || rtc_event_in || sens_hit) begin
					next_st.cnt = wake_cycles(PMW_REQ_IDLE);
					next_st.fsm = ST_WAKE_WAIT;
				end
			end
			ST_STANDBY: begin
				if (ext_wake_in || rtc_event_in || sens_hit) begin
					next_st.resume = 1'b1;
					next_st.cnt = wake_cycles(PMW_REQ_STANDBY);
					next_st.fsm = ST_WAKE_WAIT;
				end
			end
			ST_SHUTDOWN: begin
				if (|((pins_s ^ st.prev_pins) & gpio_wake_en_in[NPIN-1:0])) begin
					next_st.wake_reset = 1'b1;
					next_st.cause = CAUSE_WAKEPIN;
					next_st.cnt = wake_cycles(PMW_REQ_SHUTDOWN);
					next_st.fsm = ST_WAKE_WAIT;
				end
			end
			ST_LOWEST_A: begin
				// only the reset pin, handled below, leaves this mode
			end
			ST_WAKE_WAIT: begin
				if (st.cnt == '0) begin
					next_st.fsm = st.wake_reset ? ST_RESET_OUT : ST_ACTIVE;
				end
			end
			ST_RESET_OUT: begin
				next_st.wake_reset = 1'b0;
				next_st.resume = 1'b0;
				next_st.fsm = ST_ACTIVE;
			end
			default: next_st.fsm = ST_ACTIVE;
		endcase
		if (st.fsm == ST_ACTIVE && st.resume) begin
			next_st.resume = 1'b0;
		end
		// reset pin falling edge wins from any mode
		if (st.rst_prev && !rst_n_s) begin
			next_st.cause = CAUSE_PIN;
			next_st.wake_reset = 1'b1;
			next_st.resume = 1'b0;
			next_st.cnt = (st.fsm == ST_SHUTDOWN || st.fsm == ST_LOWEST_A) ?
				wake_cycles(PMW_REQ_SHUTDOWN) : 17'h1;
			next_st.fsm = ST_WAKE_WAIT;
		end
		// rtc tick on rising slow clock edge, skipping pulses when compensating rc
		next_st.slow_prev = slow_clk_sel_out ? slow_x_s : slow_r_s;
		if (next_st.slow_prev && !st.slow_prev) begin
			if (rtc_comp_en_in && !slow_clk_sel_out) begin
				next_st.comp_acc = {1'b0, st.comp_acc[7:0]} + {1'b0, rtc_comp_in};
				next_st.tick = !next_st.comp_acc[8];
			end else begin
				next_st.tick = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st <= '0;
			st.fsm <= ST_ACTIVE;
			st.target <= PMW_REQ_ACTIVE;
			st.cause <= CAUSE_RESET_VAL; // power-on reset cause
			st.rst_prev <= 1'b0; // synchroniser leaves reset low, so no false pin edge
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs decoded from state
	logic run;
	assign run = (st.fsm == ST_ACTIVE) || (st.fsm == ST_ENTER_GATE && st.cnt == 17'(ENTRY_STEP_CYC));
	assign cpu_clk_en_out = run;
	assign mem_clk_en_out = run;
	assign periph_clk_en_out = (st.fsm inside {ST_ACTIVE, ST_ENTER_GATE, ST_IDLE, ST_WAKE_WAIT});
	assign main_pwr_en_out = !(st.fsm inside {ST_STANDBY, ST_SHUTDOWN, ST_LOWEST_A});
	assign always_on_domain_en_out = (st.fsm != ST_SHUTDOWN);
	assign sens_pwr_en_out = !(st.fsm inside {ST_SHUTDOWN, ST_LOWEST_A});
	assign retain_en_out = (st.fsm == ST_STANDBY);
	assign fast_pll_x2_out = main_pwr_en_out; // crystal reference doubled
	assign fast_crystal_osc_en_out = main_pwr_en_out;
	assign io_hold_out = (st.fsm inside {ST_ENTER_LATCH, ST_STANDBY, ST_SHUTDOWN, ST_LOWEST_A});
	assign io_latched_out = st.latched;
	assign mode_out = st.fsm == ST_ACTIVE ? PMW_REQ_ACTIVE : st.target;
	assign sys_reset_n_out = (st.fsm != ST_RESET_OUT);
	assign reset_cause_out = st.cause;
	assign cpu_resume_out = st.resume && st.fsm == ST_ACTIVE;
	assign slow_clk_sel_out = slow_xtal_fitted_in ? SLOW_SEL_XTAL : SLOW_SEL_RC;
	assign clkout_pin_out = clkout_en_in && st.slow_prev;
	assign rtc_tick_out = st.tick && always_on_domain_en_out;

	// ==========================================================
	// checks
	sequence s_enter_deep;
		st.fsm == ST_ENTER_LATCH;
	endsequence
	a_hold_before_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		!main_pwr_en_out && $past(main_pwr_en_out) |-> $past(io_hold_out))
		else $error("power removed before pins latched");
	a_idle_clk_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.fsm == ST_IDLE |-> !cpu_clk_en_out && !mem_clk_en_out && periph_clk_en_out)
		else $error("idle clocks wrong");
	a_idle_irq_wake: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.fsm == ST_IDLE && irq_any_in && rst_n_s |=> st.fsm == ST_WAKE_WAIT)
		else $error("interrupt did not wake idle");
	a_stby_power: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.fsm == ST_STANDBY |-> always_on_domain_en_out && !main_pwr_en_out && io_hold_out)
		else $error("standby power wrong");
	a_stby_no_irq: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.fsm == ST_STANDBY && !ext_wake_in && !rtc_event_in && !sens_hit
		&& !(st.rst_prev && !rst_n_s) |=> st.fsm == ST_STANDBY)
		else $error("standby left without wake source");
	a_shdn_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.fsm == ST_SHUTDOWN |-> !always_on_domain_en_out && !sens_pwr_en_out)
		else $error("shutdown left a domain on");
	a_latch_stable: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		s_enter_deep ##1 st.fsm != ST_ACTIVE |-> $stable(io_latched_out))
		else $error("latched pins changed");
	a_wake_cause: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.fsm == ST_RESET_OUT |-> reset_cause_out != CAUSE_POR)
		else $error("reset cause not recorded");
	a_idle_latency: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
		st.fsm == ST_WAKE_WAIT && st.cnt != '0 |=> st.fsm == ST_WAKE_WAIT)
		else $error("wake too fast");
endmodule : pmw_ctrl
`default_nettype wire

//--- verif/pmw_far_model.sv
// Purpose: far-side model of wake pin, reset pin, rtc, sensor and slow clocks
// Assumes: bench commands arrive on the reference clock
// Notes: events stand 6 cycles so the pin synchroniser surely sees them
`timescale 1ns/1ps
`default_nettype none
module pmw_far_model #(
	parameter int NPIN = 4
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// bench command: 1 ext wake, 2 rtc, 3 sensor, 4 reset pin
	input wire logic cmd_valid_in,
	input wire logic [2:0] cmd_in,
	input wire logic [NPIN-1:0] pins_in,
	// device-facing sources
	output logic ext_wake_out,
	output logic rtc_event_out,
	output logic sens_event_out,
	output logic reset_pin_n_out,
	output logic [NPIN-1:0] gpio_val_out,
	output logic slow_xtal_out,
	output logic slow_rc_out
);
	logic [2:0] cmd;
	logic [3:0] left;
	logic [4:0] div;
	// ==========================================
	// event shaping and slow clock dividers
	// slow clocks share the reference phase, a known limitation of this model
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cmd <= 3'h0;
			left <= 4'h0;
			div <= 5'h00;
		end else begin
			div <= div + 5'h01;
			if (cmd_valid_in) begin
				cmd <= cmd_in;
				left <= 4'h6;
			end else if (left != 4'h0) begin
				left <= left - 4'h1;
			end
		end
	end
	// sources high only while a command stands, except the reset pin, which is driven low then
	assign ext_wake_out = (left != 4'h0) && (cmd == 3'h1);
	assign rtc_event_out = (left != 4'h0) && (cmd == 3'h2);
	assign sens_event_out = (left != 4'h0) && (cmd == 3'h3);
	assign reset_pin_n_out = !((left != 4'h0) && (cmd == 3'h4));
	assign gpio_val_out = pins_in;
	assign slow_xtal_out = div[2];
	assign slow_rc_out = div[4];
endmodule : pmw_far_model
`default_nettype wire

//--- verif/power_mode_wake_controller_tb.sv
// Purpose: self-checking bench for the power-mode and wake controller
// Assumes: shortened wake counts 4, 16 and 40 cycles
// Notes: wake times are checked within a small window for synchroniser slack
`timescale 1ns/1ps
`default_nettype none
module power_mode_wake_controller_tb;
	import pmw_pkg::*;
	localparam int WI = 4;
	localparam int WS = 16;
	localparam int WD = 40;
	logic ref_clk_in, rstn_in, mode_req_valid_in, irq_any_in, ext_wake_in, rtc_event_in;
	logic sens_event_in, reset_pin_n_in, slow_xtal_fitted_in, slow_clk_xtal_in;
	logic slow_clk_rc_in, clkout_en_in, cmd_v, clk_prev;
	pmw_req_t mode_req_in;
	logic [15:0] sens_wake_mask_in, sens_cond_in;
	logic [3:0] gpio_val_in, gpio_wake_en_in, pins, io_latched_out;
	logic [2:0] cmd, mode_out;
	logic [1:0] reset_cause_out;
	logic cpu_clk_en_out, mem_clk_en_out, periph_clk_en_out, main_pwr_en_out;
	logic always_on_domain_en_out, sens_pwr_en_out, retain_en_out, fast_pll_x2_out;
	logic fast_crystal_osc_en_out, io_hold_out, sys_reset_n_out, cpu_resume_out;
	logic slow_clk_sel_out, clkout_pin_out, rtc_tick_out;
	int miscompares = 0;
	int total_checks = 0;
	int rst_lows = 0;
	int resumes = 0;
	int ticks = 0;
	int edges = 0;
	int n, snap;
	// design and far side
	pmw_ctrl #(.NPIN(4), .WAKE_IDLE(WI), .WAKE_STBY(WS), .WAKE_SHDN(WD)) dut_u (
		.ref_clk_in, .rstn_in, .mode_req_valid_in, .mode_req_in, .irq_any_in,
		.ext_wake_in, .rtc_event_in, .sens_event_in, .sens_wake_mask_in, .sens_cond_in,
		.reset_pin_n_in, .gpio_val_in, .gpio_wake_en_in, .slow_xtal_fitted_in,
		.slow_clk_xtal_in, .slow_clk_rc_in, .rtc_comp_en_in(1'b0), .rtc_comp_in(8'h00),
		.clkout_en_in, .cpu_clk_en_out, .mem_clk_en_out, .periph_clk_en_out,
		.main_pwr_en_out, .always_on_domain_en_out, .sens_pwr_en_out, .retain_en_out,
		.fast_pll_x2_out, .fast_crystal_osc_en_out, .io_hold_out, .io_latched_out,
		.mode_out, .sys_reset_n_out, .reset_cause_out, .cpu_resume_out,
		.slow_clk_sel_out, .clkout_pin_out, .rtc_tick_out);
	pmw_far_model #(.NPIN(4)) far_u (.ref_clk_in, .rstn_in, .cmd_valid_in(cmd_v),
		.cmd_in(cmd), .pins_in(pins), .ext_wake_out(ext_wake_in),
		.rtc_event_out(rtc_event_in), .sens_event_out(sens_event_in),
		.reset_pin_n_out(reset_pin_n_in), .gpio_val_out(gpio_val_in),
		.slow_xtal_out(slow_clk_xtal_in), .slow_rc_out(slow_clk_rc_in));
	// ==========================================
	// clock and output event counters
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		rst_lows += (sys_reset_n_out === 1'b0);
		resumes += (cpu_resume_out === 1'b1);
		ticks += (rtc_tick_out === 1'b1);
		edges += (clkout_pin_out !== clk_prev);
		clk_prev <= clkout_pin_out;
	end
	// ==========================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk_in);
		#1;
	endtask : step
	task automatic req(input pmw_req_t m);
		@(posedge ref_clk_in) mode_req_valid_in <= 1'b1;
		mode_req_in <= m;
		@(posedge ref_clk_in) mode_req_valid_in <= 1'b0;
		step(10);
	endtask : req
	task automatic far(input logic [2:0] c);
		@(posedge ref_clk_in) cmd_v <= 1'b1;
		cmd <= c;
		@(posedge ref_clk_in) cmd_v <= 1'b0;
		#1;
	endtask : far
	// bounded wait for the cpu clock, then judge the wake time
	task automatic wake_time(input int w);
		n = 0;
		while (cpu_clk_en_out !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		check("wake time", n >= w && n <= w + 8, 1'b1);
		step(12);
		check("mode back", mode_out, PMW_REQ_ACTIVE);
	endtask : wake_time
	// ==========================================
	// scenarios
	task automatic t_idle();
		req(PMW_REQ_IDLE);
		check("idle cpu clk", cpu_clk_en_out, 1'b0);
		check("idle mem clk", mem_clk_en_out, 1'b0);
		check("idle periph clk", periph_clk_en_out, 1'b1);
		req(PMW_REQ_STANDBY);
		check("request in idle", mode_out, PMW_REQ_IDLE);
		@(posedge ref_clk_in) irq_any_in <= 1'b1;
		wake_time(WI + 2);
		irq_any_in <= 1'b0;
	endtask : t_idle
	task automatic t_standby(input logic [2:0] src);
		pins <= 4'ha;
		step(6);
		snap = resumes;
		req(PMW_REQ_STANDBY);
		check("stby main pwr", main_pwr_en_out, 1'b0);
		check("stby aon", always_on_domain_en_out, 1'b1);
		check("stby hold", io_hold_out, 1'b1);
		check("stby retain", retain_en_out, 1'b1);
		pins <= 4'h5;
		@(posedge ref_clk_in) irq_any_in <= 1'b1;
		sens_cond_in <= 16'h0002;
		far(3'h3);
		step(8);
		irq_any_in <= 1'b0;
		check("stby ignores irq", mode_out, PMW_REQ_STANDBY);
		check("stby latched", io_latched_out, 4'ha);
		sens_cond_in <= 16'h0001;
		far(src);
		wake_time(WS + 2);
		check("resume pulse", resumes - snap, 1);
	endtask : t_standby
	task automatic t_shutdown();
		pins <= 4'h6;
		gpio_wake_en_in <= 4'h1;
		step(6);
		req(PMW_REQ_SHUTDOWN);
		check("shdn aon", always_on_domain_en_out, 1'b0);
		check("shdn sens pwr", sens_pwr_en_out, 1'b0);
		pins <= 4'h4;
		far(3'h2);
		step(10);
		check("shdn stays", mode_out, PMW_REQ_SHUTDOWN);
		check("shdn latched", io_latched_out, 4'h6);
		snap = rst_lows;
		pins <= 4'h5;
		wake_time(WD + 2);
		check("wake reset pulse", rst_lows - snap, 1);
		check("cause wake pin", reset_cause_out, CAUSE_WAKEPIN);
	endtask : t_shutdown
	task automatic t_lowest();
		req(PMW_REQ_LOWEST_A);
		check("lowest aon", always_on_domain_en_out, 1'b1);
		pins <= 4'h4;
		far(3'h2);
		step(10);
		check("lowest ignores", mode_out, PMW_REQ_LOWEST_A);
		far(3'h4);
		wake_time(WD);
		check("cause reset pin", reset_cause_out, CAUSE_PIN);
	endtask : t_lowest
	task automatic t_clock();
		clkout_en_in <= 1'b1;
		step(4);
		check("rc selected", slow_clk_sel_out, SLOW_SEL_RC);
		check("fast x2", fast_pll_x2_out, 1'b1);
		snap = edges;
		n = ticks;
		step(200);
		check("clkout runs", edges > snap, 1'b1);
		check("rtc ticks", ticks > n, 1'b1);
		slow_xtal_fitted_in <= 1'b1;
		clkout_en_in <= 1'b0;
		step(8);
		check("xtal selected", slow_clk_sel_out, SLOW_SEL_XTAL);
		snap = edges;
		step(60);
		check("clkout off", edges, snap);
	endtask : t_clock
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// ==========================================
	// main sequence and watchdog
	initial begin
		{rstn_in, mode_req_valid_in, irq_any_in, cmd_v, clkout_en_in} = 5'h00;
		{slow_xtal_fitted_in, clk_prev, cmd, pins, gpio_wake_en_in} = 13'h0000;
		mode_req_in = PMW_REQ_ACTIVE;
		sens_wake_mask_in = 16'h0001;
		sens_cond_in = 16'h0000;
		repeat (10) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		step(4);
		check("reset mode", mode_out, PMW_REQ_ACTIVE);
		check("reset cause", reset_cause_out, CAUSE_POR);
		check("reset hold", io_hold_out, 1'b0);
		t_idle();
		for (int s = 1; s <= 3; s++) begin
			t_standby(s[2:0]);
		end
		t_shutdown();
		t_lowest();
		t_clock();
		test_done();
	end
	initial begin
		#500000;
		miscompares++;
		test_done();
	end
endmodule : power_mode_wake_controller_tb
`default_nettype wire
